/* File: bdh_consts.svh */
// Constants for the bus data-phase, hold and lock block.
// Included by bdh_wbuf and bdh_top, not by the package; holds definitions only.
`ifndef BDH_CONSTS_SVH
`define BDH_CONSTS_SVH

// ==========================================
// Request lengths, as coded on the length lines
`define BDH_LEN_BYTE 3'h0
`define BDH_LEN_HALF 3'h1
`define BDH_LEN_WORD 3'h2
`define BDH_LEN_DWORD 3'h3
`define BDH_LEN_3WORD 3'h4
`define BDH_LEN_4WORD 3'h5
`define BDH_LEN_BURST8 3'h6

// ==========================================
// Beat counts and queue sizing
`define BDH_BURST8_BEATS_64 4'h4
`define BDH_BURST8_BEATS_32 4'h8
`define BDH_ORDER_DEPTH 3'h4
`define BDH_ORDER_READY_MAX 3'h2
`define BDH_BUF_DEPTH 2'h2

// ==========================================
// Pin levels and field positions
`define BDH_ADDR_ODD_WORD 2
`define BDH_STRAP_WIDTH32 1'h1
`define BDH_UPPER_LANES_IDLE 4'hf
`define BDH_ALL_LANES_IDLE 8'hff

`endif

/* File: bdh_pkg.sv */
// Types shared by the bus data-phase, hold and lock block.
// Constants live in bdh_consts.svh; this package holds types only.
package bdh_pkg;

  // Request from the core towards the request bus
  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] len;
    logic write;
    logic lock;
  } bdh_req_t;

  // One write beat: data, active-low lane strobes, check bits
  typedef struct packed {
    logic [63:0] data;
    logic [7:0] lane_n;
    logic [7:0] check;
  } bdh_wbeat_t;

  // One read beat handed back to the core
  typedef struct packed {
    logic [63:0] data;
    logic [7:0] check;
    logic [2:0] word_idx;
  } bdh_rbeat_t;

  // Outstanding transaction, oldest first
  typedef struct packed {
    logic write;
    logic [3:0] beats;
    logic burst8;
    logic [2:0] start;
  } bdh_order_t;

  typedef enum logic [2:0] {
    BDH_H_RUN = 3'b000,
    BDH_H_PARK = 3'b001,
    BDH_H_HELD = 3'b010,
    BDH_H_REL1 = 3'b011,
    BDH_H_REL2 = 3'b100
  } bdh_hold_state_t;

endpackage

/* File: bdh_wbuf.sv */
// Two-entry write-beat buffer with valid/ready on both sides.
// Assumes one clock; in_ready_o is a flop so it can feed a top output.
`timescale 1ns/1ps
`include "bdh_consts.svh"

module bdh_wbuf (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic in_valid_i,
  input bdh_pkg::bdh_wbeat_t in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output bdh_pkg::bdh_wbeat_t out_data_o,
  input wire logic out_ready_i
);

  bdh_pkg::bdh_wbeat_t mem_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;
  logic [1:0] cnt_d;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && (cnt_q != 2'h0);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o = mem_q[rp_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  // ==========================================
  // Pointers and fill level
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
      in_ready_o <= 1'b0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_d;
      // Registered ready: full means the source really stalls
      in_ready_o <= (cnt_d != `BDH_BUF_DEPTH);
    end
  end

endmodule

/* File: bdh_top.sv */
// Processor-side external bus logic: request issue, data phase,
// bus release handshake and width strap.
// Assumes the partner runs on clk_i; all bus pins are same-domain.
//
// Behaviour
// RULE_01 - Eight-word bursts go out with address bit 2 clear; wrap order decoded.
// RULE_02 - Write data is driven two edges after sampling the data-phase strobe.
// RULE_03 - Writes take one beat per touched bus-width block, at most four words.
// RULE_04 - One active-low lane strobe per byte; low only for written bytes.
// RULE_05 - Eight check bits travel in the same beats as the data; the code floats them on 32-bit write beats.
// RULE_06 - Data, lanes, check bits driven only in a strobed write beat, else float.
// RULE_07 - Partner inserts one idle cycle between read and write beats.
// RULE_08 - One strobe serves reads and writes; oldest request decides direction.
// RULE_09 - Width strap sampled in reset on order pin: low 64-bit, high 32-bit.
// RULE_10 - On release request stop issuing, park strobe high, then float lines.
// RULE_11 - Grant rises in the same cycle the request lines float.
// RULE_12 - Partner holds the release request until the grant appears.
// RULE_13 - Grant rises no later than six edges after release request sampled.
// RULE_14 - Request dropped at edge n: lines driven and grant dropped at n+2.
// RULE_15 - Partner waits a cycle after grant falls before requesting again.
// RULE_16 - Release requests are honoured while the block is in reset.
// RULE_17 - Release never touches the data phase; outstanding beats continue.
// RULE_18 - Partner strobes only for this device's genuine data beats.
// RULE_19 - Partner protects at least the aligned 32-byte block of a lock.
// RULE_20 - Lock line asserted on the read of a swap pair.
// RULE_21 - Release and locked read on one edge: still float and grant.
// RULE_22 - Partner keeps the bus clock running for release in low power.
`timescale 1ns/1ps
`include "bdh_consts.svh"

module bdh_top (
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Core request side
  input wire logic req_valid_i,
  input bdh_pkg::bdh_req_t req_i,
  output logic req_ready_o,
  input wire logic wbeat_valid_i,
  input bdh_pkg::bdh_wbeat_t wbeat_i,
  output logic wbeat_ready_o,
  output logic rbeat_valid_o,
  output bdh_pkg::bdh_rbeat_t rbeat_o,
  output logic width32_o,
  // Request bus pins
  output logic [31:0] addr_o,
  output logic [2:0] len_o,
  output logic request_strobe_n_o,
  output logic wr_o,
  output logic lock_o,
  output logic req_oe_n_o,
  // Release handshake pins
  input wire logic hold_req_i,
  output logic hold_ack_o,
  // Data bus pins
  input wire logic data_phase_strobe_i,
  input wire logic first_word_order_select_i,
  input wire logic [63:0] data_i,
  output logic [63:0] data_o,
  output logic [1:0] data_oe_n_o,
  output logic [7:0] byte_lane_strobe_n_o,
  output logic byte_lane_oe_n_o,
  input wire logic [7:0] check_bits_i,
  output logic [7:0] check_bits_o,
  output logic check_oe_n_o
);

  // ==========================================
  // Reset tracking and width strap
  logic [1:0] rst_sync_q;
  logic in_reset;
  logic width32_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign in_reset = !rst_sync_q[1];

  // Not on the async reset, so it keeps tracking the pin during reset
  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      width32_q <= (first_word_order_select_i == `BDH_STRAP_WIDTH32); // RULE_09
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      width32_o <= 1'b0;
    end else begin
      width32_o <= width32_q;
    end
  end

  // ==========================================
  // Bus release state machine
  // Free of the async reset so that release still works in reset
  bdh_pkg::bdh_hold_state_t hstate_q;

  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      hstate_q <= hold_req_i ? bdh_pkg::BDH_H_HELD : bdh_pkg::BDH_H_RUN; // RULE_16
      hold_ack_o <= hold_req_i; // RULE_16
      req_oe_n_o <= 1'b1;
    end else begin
      unique case (hstate_q)
        bdh_pkg::BDH_H_RUN: begin
          req_oe_n_o <= 1'b0;
          if (hold_req_i) begin
            // Issue is blocked this edge, so the strobe parks high
            hstate_q <= bdh_pkg::BDH_H_PARK; // RULE_10
          end
        end
        bdh_pkg::BDH_H_PARK: begin
          hstate_q <= bdh_pkg::BDH_H_HELD;
          req_oe_n_o <= 1'b1; // RULE_10
          hold_ack_o <= 1'b1; // RULE_11 RULE_13 RULE_21
        end
        bdh_pkg::BDH_H_HELD: begin
          if (!hold_req_i) begin
            hstate_q <= bdh_pkg::BDH_H_REL1;
          end
        end
        bdh_pkg::BDH_H_REL1: begin
          hstate_q <= bdh_pkg::BDH_H_REL2;
        end
        bdh_pkg::BDH_H_REL2: begin
          hstate_q <= bdh_pkg::BDH_H_RUN;
          req_oe_n_o <= 1'b0; // RULE_14
          hold_ack_o <= 1'b0; // RULE_14
        end
        default: begin
          hstate_q <= bdh_pkg::BDH_H_RUN;
          req_oe_n_o <= 1'b1;
          hold_ack_o <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // Beat count of a request
  function automatic logic [3:0] beats_of(input logic [2:0] len,
                                          input logic [3:0] lo,
                                          input logic w32);
    logic [4:0] bytes;
    logic [4:0] hi;
    begin
      unique case (len)
        `BDH_LEN_BYTE: bytes = 5'h01;
        `BDH_LEN_HALF: bytes = 5'h02;
        `BDH_LEN_WORD: bytes = 5'h04;
        `BDH_LEN_DWORD: bytes = 5'h08;
        `BDH_LEN_3WORD: bytes = 5'h0c;
        default: bytes = 5'h10;
      endcase
      hi = {1'b0, lo} + bytes - 5'h01;
      if (len == `BDH_LEN_BURST8) begin
        beats_of = w32 ? `BDH_BURST8_BEATS_32 : `BDH_BURST8_BEATS_64;
      end else if (w32) begin
        beats_of = {1'b0, hi[4:2] - {1'b0, lo[3:2]}} + 4'h1; // RULE_03
      end else begin
        beats_of = {2'h0, hi[4:3] - {1'b0, lo[3]}} + 4'h1; // RULE_03
      end
    end
  endfunction

  // ==========================================
  // Request issue
  logic accept;
  logic [31:0] req_addr;
  logic pop;
  logic [2:0] ocnt_q;
  logic [2:0] ocnt_d;

  assign accept = req_valid_i && req_ready_o && !hold_req_i; // RULE_10

  always_comb begin
    req_addr = req_i.addr;
    if (req_i.len == `BDH_LEN_BURST8) begin
      req_addr[`BDH_ADDR_ODD_WORD] = 1'b0; // RULE_01
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      request_strobe_n_o <= 1'b1;
      addr_o <= 32'h0000_0000;
      len_o <= 3'h0;
      wr_o <= 1'b0;
      lock_o <= 1'b0;
      req_ready_o <= 1'b0;
    end else begin
      request_strobe_n_o <= !accept;
      if (accept) begin
        addr_o <= req_addr;
        len_o <= req_i.len;
        wr_o <= req_i.write;
        lock_o <= req_i.lock; // RULE_20
      end
      req_ready_o <= !in_reset && (hstate_q == bdh_pkg::BDH_H_RUN) && !hold_req_i
        && (ocnt_d <= `BDH_ORDER_READY_MAX);
    end
  end

  // ==========================================
  // Outstanding order queue, oldest at the read pointer
  bdh_pkg::bdh_order_t order_q [4];
  bdh_pkg::bdh_order_t head;
  logic [1:0] owp_q;
  logic [1:0] orp_q;
  logic [3:0] beat_q;
  logic [2:0] wrap_start_q;
  logic strobe_hit;
  logic [2:0] beat_start;
  logic [2:0] word_idx;

  assign head = order_q[orp_q];
  // Strobes with nothing outstanding are ignored
  assign strobe_hit = data_phase_strobe_i && (ocnt_q != 3'h0); // RULE_18
  assign pop = strobe_hit && (beat_q + 4'h1 == head.beats);

  always_comb begin
    ocnt_d = ocnt_q;
    if (accept && !pop) begin
      ocnt_d = ocnt_q + 3'h1;
    end else if (pop && !accept) begin
      ocnt_d = ocnt_q - 3'h1;
    end
  end

  // Wrap start of a burst comes from the order pin on its first beat
  always_comb begin
    beat_start = 3'h0;
    if (head.burst8 && first_word_order_select_i) begin
      beat_start = width32_q ? head.start : {1'b0, head.start[2:1]}; // RULE_01
    end
    if (beat_q != 4'h0) begin
      beat_start = wrap_start_q;
    end
    if (width32_q) begin
      word_idx = beat_start + beat_q[2:0];
    end else begin
      word_idx = {beat_start[1:0] + beat_q[1:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i) begin
    if (accept) begin
      order_q[owp_q] <= '{write: req_i.write,
                          beats: beats_of(req_i.len, req_i.addr[3:0], width32_q),
                          burst8: (req_i.len == `BDH_LEN_BURST8),
                          start: req_addr[4:2]};
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      owp_q <= 2'h0;
      orp_q <= 2'h0;
      ocnt_q <= 3'h0;
      beat_q <= 4'h0;
      wrap_start_q <= 3'h0;
    end else begin
      if (accept) begin
        owp_q <= owp_q + 2'h1;
      end
      ocnt_q <= ocnt_d;
      if (strobe_hit) begin
        wrap_start_q <= beat_start;
        if (pop) begin
          orp_q <= orp_q + 2'h1; // RULE_08
          beat_q <= 4'h0;
        end else begin
          beat_q <= beat_q + 4'h1;
        end
      end
    end
  end

  // ==========================================
  // Data phase pipeline: strobe at edge n, bus beat at edge n+2
  // Independent of the release state machine throughout
  logic s1_wr_q;
  logic s1_rd_q;
  logic s2_rd_q;
  logic [2:0] s1_idx_q;
  logic [2:0] s2_idx_q;
  logic buf_valid;
  bdh_pkg::bdh_wbeat_t buf_beat;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_wr_q <= 1'b0;
      s1_rd_q <= 1'b0;
      s2_rd_q <= 1'b0;
      s1_idx_q <= 3'h0;
      s2_idx_q <= 3'h0;
    end else begin
      s1_wr_q <= strobe_hit && head.write; // RULE_08 RULE_17
      s1_rd_q <= strobe_hit && !head.write; // RULE_08 RULE_17
      s1_idx_q <= word_idx;
      s2_rd_q <= s1_rd_q;
      s2_idx_q <= s1_idx_q;
    end
  end

  bdh_wbuf i_bdh_wbuf (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(wbeat_valid_i),
    .in_data_i(wbeat_i),
    .in_ready_o(wbeat_ready_o),
    .out_valid_o(buf_valid),
    .out_data_o(buf_beat),
    .out_ready_i(s1_wr_q)
  );

  // Driven for exactly the beat cycle; an empty buffer drives no lanes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_o <= 64'h0000_0000_0000_0000;
      data_oe_n_o <= 2'h3;
      byte_lane_strobe_n_o <= `BDH_ALL_LANES_IDLE;
      byte_lane_oe_n_o <= 1'b1;
      check_bits_o <= 8'h00;
      check_oe_n_o <= 1'b1;
    end else begin
      data_o <= buf_beat.data;
      check_bits_o <= buf_beat.check; // RULE_05
      byte_lane_strobe_n_o <= buf_valid ? buf_beat.lane_n : `BDH_ALL_LANES_IDLE; // RULE_04
      if (width32_q) begin
        // Upper lanes hold a steady idle level in 32-bit mode
        byte_lane_strobe_n_o[7:4] <= `BDH_UPPER_LANES_IDLE;
      end
      data_oe_n_o[0] <= !s1_wr_q; // RULE_02 RULE_06
      data_oe_n_o[1] <= !(s1_wr_q && !width32_q); // RULE_06
      byte_lane_oe_n_o <= !s1_wr_q; // RULE_06
      check_oe_n_o <= !(s1_wr_q && !width32_q); // RULE_05 RULE_06
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rbeat_valid_o <= 1'b0;
      rbeat_o <= '0;
    end else begin
      rbeat_valid_o <= s2_rd_q;
      if (s2_rd_q) begin
        rbeat_o <= '{data: data_i, check: check_bits_i, word_idx: s2_idx_q}; // RULE_05
      end
    end
  end

endmodule

/* File: bdh_top_asserts.sv */
// Concurrent checks on the pins of bdh_top.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
module bdh_top_asserts (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input bdh_pkg::bdh_req_t req_i,
  input wire logic rbeat_valid_o,
  input wire logic width32_o,
  input wire logic [31:0] addr_o,
  input wire logic [2:0] len_o,
  input wire logic request_strobe_n_o,
  input wire logic wr_o,
  input wire logic lock_o,
  input wire logic req_oe_n_o,
  input wire logic hold_req_i,
  input wire logic hold_ack_o,
  input wire logic data_phase_strobe_i,
  input wire logic [1:0] data_oe_n_o,
  input wire logic [7:0] byte_lane_strobe_n_o,
  input wire logic byte_lane_oe_n_o,
  input wire logic check_oe_n_o
);
  // ==========================================
  // Pin relations
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wr_drive_a: assert property (!data_oe_n_o[0] |-> $past(data_phase_strobe_i, 2))
    else $error("data bus driven without strobe");
  lane_tie_a: assert property (byte_lane_oe_n_o == data_oe_n_o[0])
    else $error("lane strobes float apart from data");
  upper_float_a: assert property ((check_oe_n_o == (data_oe_n_o[0] | width32_o))
    && (data_oe_n_o[1] == (data_oe_n_o[0] | width32_o)))
    else $error("check bits or upper data wrongly driven");
  upper_lanes_a: assert property (width32_o && !byte_lane_oe_n_o
    |-> byte_lane_strobe_n_o[7:4] == 4'hf)
    else $error("upper lanes active on narrow bus");
  ack_bound_a: assert property ($rose(hold_req_i) |-> ##[1:7] hold_ack_o)
    else $error("grant late");
  float_grant_a: assert property (hold_ack_o |-> req_oe_n_o)
    else $error("grant while request lines driven");
  no_issue_a: assert property (hold_req_i |=> request_strobe_n_o)
    else $error("request issued during release");
  release_exit_a: assert property ($fell(hold_req_i) && hold_ack_o
    |=> hold_ack_o [*2] ##1 (!hold_ack_o && !req_oe_n_o))
    else $error("release exit timing wrong");
  read_beat_a: assert property (rbeat_valid_o |-> $past(data_phase_strobe_i, 3))
    else $error("read beat without strobe");
  burst_align_a: assert property (!request_strobe_n_o && len_o == 3'h6 |-> !addr_o[2])
    else $error("burst address odd word");
  lock_pass_a: assert property (!request_strobe_n_o
    |-> lock_o == $past(req_i.lock) && wr_o == $past(req_i.write))
    else $error("lock or direction not passed");
endmodule

bind bdh_top bdh_top_asserts i_bdh_top_asserts (.*);

/* File: bdh_partner.sv */
// Behavioural memory controller facing the bus pins of bdh_top.
// Assumes bdh_top is the only requester; the bench drives hold and order pin.
`timescale 1ns/1ps
module bdh_partner (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic request_strobe_n_i,
  input wire logic wr_i,
  input wire logic [2:0] len_i,
  input wire logic width32_i,
  input wire logic slow_i,
  input wire logic [63:0] data_i,
  input wire logic data_oe_n_i,
  input wire logic [7:0] lane_n_i,
  input wire logic [7:0] check_i,
  output logic strobe_o,
  output logic [63:0] data_o,
  output logic [7:0] check_o
);
  logic [4:0] txq[$];
  logic [80:0] wq[$];
  logic [63:0] rd_val = 64'h0123_4567_89ab_0000;
  logic [1:0] rd_p = 2'h0;
  logic [1:0] wr_p = 2'h0;
  logic cur_wr;
  logic [4:0] tx;
  logic [3:0] nb;
  // ==========================================
  // Read data: released lines show the inverse, never a stale copy
  assign data_o = rd_p[1] ? rd_val : ~rd_val;
  assign check_o = rd_p[1] ? rd_val[7:0] : ~rd_val[7:0];
  always @(posedge clk_i) begin
    nb = len_i == 3'h6 ? (width32_i ? 4'h8 : 4'h4) : 4'h1;
    if (len_i == 3'h5)
      nb = width32_i ? 4'h4 : 4'h2;
    if (!arst_n_i)
      txq.delete();
    else if (!request_strobe_n_i)
      txq.push_back({wr_i, nb});
    rd_p <= {rd_p[0], strobe_o & !cur_wr};
    wr_p <= {wr_p[0], strobe_o & cur_wr};
    if (rd_p[1])
      rd_val <= rd_val + 64'h1;
    if (wr_p[1])
      wq.push_back({data_oe_n_i, check_i, lane_n_i, data_i});
  end
  // ==========================================
  // Strobe sequencer, oldest request first
  initial begin
    strobe_o = 1'b0;
    cur_wr = 1'b0;
    forever begin
      @(posedge clk_i);
      #1;
      if (txq.size() != 0) begin
        tx = txq.pop_front();
        repeat (slow_i ? 4 : 1) @(posedge clk_i);
        #1;
        if (tx[4] && !cur_wr) begin
          @(posedge clk_i);
          #1;
        end
        cur_wr = tx[4];
        // Back-to-back strobes stay high instead of dipping within one step
        repeat (tx[3:0]) begin
          strobe_o = 1'b1;
          @(posedge clk_i);
          #1;
          if (slow_i) begin
            strobe_o = 1'b0;
            @(posedge clk_i);
            #1;
          end
        end
        strobe_o = 1'b0;
      end
    end
  end
endmodule

/* File: bdh_top_bench.sv */
// Self-checking bench for bdh_top against a memory controller model.
// Assumes the design, bdh_partner and the checker are compiled first.
`timescale 1ns/1ps
module bdh_top_bench;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  bdh_pkg::bdh_req_t req_i = '0;
  logic wbeat_valid_i = 1'b0;
  bdh_pkg::bdh_wbeat_t wbeat_i = '0;
  logic hold_req_i = 1'b0;
  logic fwos = 1'b0;
  logic slow = 1'b0;
  logic req_ready, wbeat_ready, rbeat_valid, width32, strobe_n, wr, lock, req_oe_n;
  logic hold_ack, dps, lane_oe_n, chk_oe_n;
  bdh_pkg::bdh_rbeat_t rbeat;
  logic [31:0] addr;
  logic [2:0] len;
  logic [63:0] din, dout;
  logic [1:0] data_oe_n;
  logic [7:0] lanes_n, chk_in, chk_out;
  int fail_count = 0;
  int check_count = 0;
  int rd_n = 0;
  int n;
  always #50 clk_i = ~clk_i;
  bdh_top i_bdh_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready), .wbeat_valid_i(wbeat_valid_i), .wbeat_i(wbeat_i),
    .wbeat_ready_o(wbeat_ready), .rbeat_valid_o(rbeat_valid), .rbeat_o(rbeat),
    .width32_o(width32), .addr_o(addr), .len_o(len), .request_strobe_n_o(strobe_n),
    .wr_o(wr), .lock_o(lock), .req_oe_n_o(req_oe_n), .hold_req_i(hold_req_i),
    .hold_ack_o(hold_ack), .data_phase_strobe_i(dps), .first_word_order_select_i(fwos),
    .data_i(din), .data_o(dout), .data_oe_n_o(data_oe_n), .byte_lane_strobe_n_o(lanes_n),
    .byte_lane_oe_n_o(lane_oe_n), .check_bits_i(chk_in), .check_bits_o(chk_out),
    .check_oe_n_o(chk_oe_n));
  bdh_partner i_bdh_partner (.clk_i(clk_i), .arst_n_i(arst_n_i), .request_strobe_n_i(strobe_n),
    .wr_i(wr), .len_i(len), .width32_i(width32), .slow_i(slow), .data_i(dout),
    .data_oe_n_i(data_oe_n[0]), .lane_n_i(lanes_n), .check_i(chk_out), .strobe_o(dps),
    .data_o(din), .check_o(chk_in));
  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [80:0] exp, input logic [80:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_take;
    @(negedge clk_i);
    for (int i = 0; i < 50 && (req_ready !== 1'b1 || hold_req_i); i++)
      @(negedge clk_i);
    @(posedge clk_i);
    req_valid_i <= 1'b0;
  endtask
  task automatic send(input logic [31:0] a, input logic [2:0] l, input logic w, input logic k);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_i <= {a, l, w, k};
    wait_take;
  endtask
  task automatic push(input logic [63:0] d, input logic [7:0] ln, input logic [7:0] ck);
    @(posedge clk_i);
    wbeat_valid_i <= 1'b1;
    wbeat_i <= {d, ln, ck};
    @(negedge clk_i);
    for (int i = 0; i < 50 && wbeat_ready !== 1'b1; i++)
      @(negedge clk_i);
    @(posedge clk_i);
    wbeat_valid_i <= 1'b0;
  endtask
  task automatic rd_check(input logic [2:0] idx);
    for (int i = 0; i < 40 && rbeat_valid !== 1'b1; i++)
      @(negedge clk_i);
    chk("read beat", {64'h0123_4567_89ab_0000 + 64'(rd_n), 8'(rd_n), idx}, rbeat);
    rd_n++;
    @(negedge clk_i);
  endtask
  task automatic wq_wait(input int cnt);
    for (int i = 0; i < 60 && i_bdh_partner.wq.size() < cnt; i++)
      @(negedge clk_i);
  endtask
  // ==========================================
  // Scenarios
  task automatic do_reset(input logic strap);
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    fwos <= strap;
    hold_req_i <= strap;
    repeat (7) @(posedge clk_i);
    @(negedge clk_i);
    chk("grant in reset", strap, hold_ack);
    // Hold drops two edges ahead of release so its exit stays inside reset
    @(posedge clk_i);
    hold_req_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    chk("width strap", {strap, 1'b0}, {width32, hold_ack});
    $display("reset done");
  endtask
  task automatic t_read;
    @(posedge clk_i);
    fwos <= 1'b1;
    send(32'h0000_021c, 3'h6, 1'b0, 1'b0);
    @(negedge clk_i);
    chk("burst addr", {32'h0000_0218, 3'h6}, {addr, len});
    for (int i = 0; i < 4; i++)
      rd_check(3'(6 + 2 * i));
    $display("read burst done");
  endtask
  task automatic t_write;
    push(64'h1122_3344_5566_7788, 8'h00, 8'h5a);
    push(64'h99aa_bbcc_ddee_ff00, 8'hf0, 8'ha5);
    send(32'h0000_0100, 3'h5, 1'b1, 1'b0);
    wq_wait(2);
    chk("beat one", {9'h05a, 8'h00, 64'h1122_3344_5566_7788}, i_bdh_partner.wq[0]);
    chk("beat two", {9'h0a5, 8'hf0, 64'h99aa_bbcc_ddee_ff00}, i_bdh_partner.wq[1]);
    i_bdh_partner.wq.delete();
    $display("write burst done");
  endtask
  task automatic t_hold;
    @(posedge clk_i);
    slow <= 1'b1;
    send(32'h0000_0300, 3'h2, 1'b0, 1'b0);
    @(posedge clk_i);
    hold_req_i <= 1'b1;
    req_valid_i <= 1'b1;
    req_i <= {32'h0000_0320, 3'h2, 1'b0, 1'b1};
    @(negedge clk_i);
    for (n = 1; n < 8 && hold_ack !== 1'b1; n++)
      @(negedge clk_i);
    chk("grant in time", 2'h3, {n <= 6, req_oe_n});
    rd_check(3'h0);
    @(posedge clk_i);
    hold_req_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("grant kept", 1'b1, hold_ack);
    @(negedge clk_i);
    chk("grant gone", 2'h0, {hold_ack, req_oe_n});
    wait_take;
    @(negedge clk_i);
    chk("locked read", 2'h2, {lock, wr});
    rd_check(3'h0);
    slow <= 1'b0;
    $display("release done");
  endtask
  task automatic t_strap;
    do_reset(1'b1);
    push(64'hcafe_f00d_1234_5678, 8'hf3, 8'h00);
    send(32'h0000_0104, 3'h2, 1'b1, 1'b0);
    wq_wait(1);
    chk("narrow beat", {9'h0f3, 32'h1234_5678}, {i_bdh_partner.wq[0][80],
      i_bdh_partner.wq[0][71:64], i_bdh_partner.wq[0][31:0]});
    // Order pin low on the first beat: plain ascending order on the narrow bus
    @(posedge clk_i);
    fwos <= 1'b0;
    send(32'h0000_0200, 3'h6, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++)
      rd_check(3'(i));
    $display("narrow bus done");
  endtask
  initial begin
    do_reset(1'b0);
    t_read;
    t_write;
    t_hold;
    t_strap;
    test_done;
  end
  // Generous bound: the full sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk_i);
    fail_count++;
    test_done;
  end
endmodule
